// File: rtl/nvs_consts.vh
// constants for the nonvolatile byte store access controller
`ifndef NVS_CONSTS_VH
`define NVS_CONSTS_VH

// ----------------------------------------------------------------
// register indices (byte address is four times the index)
// ----------------------------------------------------------------
`define NVS_IDX_INTCTL 8'h0b
`define NVS_IDX_PFLAGS 8'h0c
`define NVS_IDX_PIRQEN 8'h8c
`define NVS_IDX_DATA 8'h9a
`define NVS_IDX_ADDR 8'h9b
`define NVS_IDX_CTRL 8'h9c
`define NVS_IDX_UNLOCK 8'h9d

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define NVS_CTRL_FETCH 0
`define NVS_CTRL_GO 1
`define NVS_CTRL_PERMIT 2
`define NVS_CTRL_ABORT 3
`define NVS_PFLAGS_DONE 7
`define NVS_PIRQEN_DONE 7
`define NVS_INTCTL_GIE 7

// ----------------------------------------------------------------
// reset values and unlock keys
// ----------------------------------------------------------------
`define NVS_RST_BYTE 8'h00
`define NVS_ERASED_BYTE 8'hff
`define NVS_KEY_FIRST 8'h55
`define NVS_KEY_SECOND 8'haa
`define NVS_UNLOCK_GAP 3'h3
`define NVS_GAP_SAT 3'h7

// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define NVS_CLK_HZ 20000000
`define NVS_POWERUP_TIMER_MS 64
`define NVS_POWERUP_TIMER_CYCLES ((`NVS_POWERUP_TIMER_MS * `NVS_CLK_HZ) / 1000)
`define NVS_WRITE_US 5000
`define NVS_WRITE_CYCLES (`NVS_WRITE_US * (`NVS_CLK_HZ / 1000000))
`define NVS_CNT_W 21

`endif

// File: rtl/nvs_ctrl.v
// nonvolatile byte store access controller with avalon-mm slave
// ----------------------------------------------------------------
// ----------------------------------------------------------------
`include "nvs_consts.vh"
`timescale 1ns/10ps
`default_nettype none

module nvs_ctrl #(
  parameter [31:0] POWERUP_TIMER_CYCLES = `NVS_POWERUP_TIMER_CYCLES,
  parameter [31:0] WRITE_CYCLES = `NVS_WRITE_CYCLES
) (
  // clock and power-on reset
  input wire clk_sys,
  input wire rstn,
  // other reset sources, asynchronous to clk_sys
  input wire ext_reset_n,
  input wire watchdog_reset,
  input wire brownout_detect,
  // avalon-mm slave
  input wire [9:0] avs_address,
  input wire avs_read,
  input wire avs_write,
  input wire [3:0] avs_byteenable,
  input wire [31:0] avs_writedata,
  output reg [31:0] avs_readdata,
  output wire avs_waitrequest
);

  // ----------------------------------------------------------------
  // local constants
  // ----------------------------------------------------------------
  localparam [`NVS_CNT_W-1:0] POWERUP_TIMER_LAST =
    POWERUP_TIMER_CYCLES[`NVS_CNT_W-1:0] - {{(`NVS_CNT_W-1){1'b0}}, 1'b1};
  localparam [`NVS_CNT_W-1:0] WRITE_LAST =
    WRITE_CYCLES[`NVS_CNT_W-1:0] - {{(`NVS_CNT_W-1){1'b0}}, 1'b1};
  localparam [1:0] SEQ_IDLE = 2'h0;
  localparam [1:0] SEQ_FIRST = 2'h1;
  localparam [1:0] SEQ_SECOND = 2'h2;

  // ----------------------------------------------------------------
  // reset release and input synchronisers
  // ----------------------------------------------------------------
  reg rst_meta_q;
  reg rst_sync_q;
  wire rst_n_int;

  always @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      rst_meta_q <= 1'b0;
      rst_sync_q <= 1'b0;
    end else begin
      rst_meta_q <= 1'b1;
      rst_sync_q <= rst_meta_q;
    end
  end
  assign rst_n_int = rst_sync_q;

  // pins settle through two flops; ext reset idles high
  reg [2:0] src_meta_q;
  reg [2:0] src_sync_q;
  wire ext_rst_hit;
  wire wdt_rst_hit;
  wire bod_hit;
  wire soft_rst;

  always @(posedge clk_sys or negedge rst_n_int) begin
    if (!rst_n_int) begin
      src_meta_q <= 3'h1;
      src_sync_q <= 3'h1;
    end else begin
      src_meta_q <= {brownout_detect, watchdog_reset, ext_reset_n};
      src_sync_q <= src_meta_q;
    end
  end
  assign ext_rst_hit = ~src_sync_q[0];
  assign wdt_rst_hit = src_sync_q[1];
  assign bod_hit = src_sync_q[2];
  assign soft_rst = ext_rst_hit | wdt_rst_hit | bod_hit;

  // ----------------------------------------------------------------
  // bus slave: one wait cycle on every access
  // ----------------------------------------------------------------
  reg ack_q;
  wire req;
  wire [7:0] idx;
  wire wr_acc;
  wire [7:0] wbyte;

  assign req = avs_read | avs_write;
  assign avs_waitrequest = req & ~ack_q;
  assign idx = avs_address[9:2];
  // upper lanes carry nothing; lane 0 must be enabled
  assign wr_acc = avs_write & ack_q & avs_byteenable[0];
  assign wbyte = avs_writedata[7:0];

  always @(posedge clk_sys or negedge rst_n_int) begin
    if (!rst_n_int) begin
      ack_q <= 1'b0;
    end else begin
      ack_q <= req & ~ack_q;
    end
  end

  function hit;
    input [7:0] a;
    input [7:0] b;
    begin
      hit = (a == b);
    end
  endfunction

  // ----------------------------------------------------------------
  // register state
  // ----------------------------------------------------------------
  reg [7:0] data_q;
  reg [7:0] addr_q;
  reg [7:0] intctl_q;
  reg pirqen_q;
  reg done_q;
  reg abort_q;
  reg permit_q;
  reg go_q;
  reg fetch_q;
  reg [7:0] mem_q [0:255];
  reg [7:0] wr_addr_q;
  reg [7:0] wr_data_q;
  reg [`NVS_CNT_W-1:0] wr_cnt_q;
  reg [`NVS_CNT_W-1:0] powerup_timer_cnt_q;
  reg powerup_timer_done_q;
  reg [1:0] seq_q;
  reg [1:0] seq_d;
  reg [2:0] gap_q;

  // ----------------------------------------------------------------
  // power-up timer
  // ----------------------------------------------------------------
  // brownout restarts the timer, just as a fresh power-up would
  always @(posedge clk_sys or negedge rst_n_int) begin
    if (!rst_n_int) begin
      powerup_timer_cnt_q <= {`NVS_CNT_W{1'b0}};
      powerup_timer_done_q <= 1'b0;
    end else if (bod_hit) begin
      powerup_timer_cnt_q <= {`NVS_CNT_W{1'b0}};
      powerup_timer_done_q <= 1'b0;
    end else if (!powerup_timer_done_q) begin
      powerup_timer_cnt_q <= powerup_timer_cnt_q + {{(`NVS_CNT_W-1){1'b0}}, 1'b1};
      powerup_timer_done_q <= (powerup_timer_cnt_q == POWERUP_TIMER_LAST);
    end
  end

  // ----------------------------------------------------------------
  // unlock sequence
  // ----------------------------------------------------------------
  wire gap_ok;
  wire wr_ctrl;
  wire wr_unlock;
  wire go_req;
  wire start_wr;
  wire end_wr;

  assign gap_ok = (gap_q == `NVS_UNLOCK_GAP);
  assign wr_ctrl = wr_acc & hit(idx, `NVS_IDX_CTRL);
  assign wr_unlock = wr_acc & hit(idx, `NVS_IDX_UNLOCK);
  // go only straight after both keys
  assign go_req = wr_ctrl & wbyte[`NVS_CTRL_GO] &
                  (seq_q == SEQ_SECOND) & gap_ok;
  assign start_wr = go_req & permit_q & powerup_timer_done_q & ~go_q & ~soft_rst;
  assign end_wr = go_q & (wr_cnt_q == WRITE_LAST) & ~soft_rst;

  // keys only move the sequencer, nothing is stored
  always @* begin
    seq_d = seq_q;
    if (soft_rst) begin
      seq_d = SEQ_IDLE;
    end else if (wr_acc) begin
      if (wr_unlock && wbyte == `NVS_KEY_FIRST) begin
        seq_d = SEQ_FIRST;
      end else if (wr_unlock && wbyte == `NVS_KEY_SECOND &&
                   seq_q == SEQ_FIRST && gap_ok) begin
        seq_d = SEQ_SECOND;
      end else begin
        seq_d = SEQ_IDLE;
      end
    end
  end

  // gap counts cycles between accepted writes, saturating
  always @(posedge clk_sys or negedge rst_n_int) begin
    if (!rst_n_int) begin
      seq_q <= SEQ_IDLE;
      gap_q <= `NVS_GAP_SAT;
    end else begin
      seq_q <= seq_d;
      if (wr_acc) begin
        gap_q <= 3'h1;
      end else if (gap_q != `NVS_GAP_SAT) begin
        gap_q <= gap_q + 3'h1;
      end
    end
  end

  // ----------------------------------------------------------------
  // control register and write timer
  // ----------------------------------------------------------------
  always @(posedge clk_sys or negedge rst_n_int) begin
    if (!rst_n_int) begin
      abort_q <= 1'b0;
      permit_q <= 1'b0;
      go_q <= 1'b0;
      fetch_q <= 1'b0;
      wr_cnt_q <= {`NVS_CNT_W{1'b0}};
      wr_addr_q <= `NVS_RST_BYTE;
      wr_data_q <= `NVS_RST_BYTE;
    end else if (soft_rst) begin
      // a cut-short write leaves the abort flag
      if (go_q) begin
        abort_q <= 1'b1;
      end
      permit_q <= 1'b0;
      go_q <= 1'b0;
      fetch_q <= 1'b0;
      wr_cnt_q <= {`NVS_CNT_W{1'b0}};
    end else begin
      fetch_q <= wr_ctrl & wbyte[`NVS_CTRL_FETCH];
      if (wr_ctrl) begin
        permit_q <= wbyte[`NVS_CTRL_PERMIT];
        abort_q <= wbyte[`NVS_CTRL_ABORT];
      end
      // go held until the timer ends
      if (start_wr) begin
        go_q <= 1'b1;
        wr_cnt_q <= {`NVS_CNT_W{1'b0}};
        wr_addr_q <= addr_q;
        wr_data_q <= data_q;
      end else if (end_wr) begin
        go_q <= 1'b0;
      end else if (go_q) begin
        wr_cnt_q <= wr_cnt_q + {{(`NVS_CNT_W-1){1'b0}}, 1'b1};
      end
    end
  end

  // ----------------------------------------------------------------
  // storage array
  // ----------------------------------------------------------------
  // cells are nonvolatile, so no reset; an aborted write leaves erased
  always @(posedge clk_sys) begin
    // erase on start, program on completion
    if (start_wr) begin
      mem_q[addr_q] <= `NVS_ERASED_BYTE;
    end else if (end_wr) begin
      mem_q[wr_addr_q] <= wr_data_q;
    end
  end

  // ----------------------------------------------------------------
  // address, data and peripheral registers
  // ----------------------------------------------------------------
  always @(posedge clk_sys or negedge rst_n_int) begin
    if (!rst_n_int) begin
      data_q <= `NVS_RST_BYTE;
      addr_q <= `NVS_RST_BYTE;
      intctl_q <= `NVS_RST_BYTE;
      pirqen_q <= 1'b0;
      done_q <= 1'b0;
    end else if (soft_rst) begin
      // address and data lost on reset
      data_q <= `NVS_RST_BYTE;
      addr_q <= `NVS_RST_BYTE;
      intctl_q <= `NVS_RST_BYTE;
      pirqen_q <= 1'b0;
      done_q <= 1'b0;
    end else begin
      // fetched byte lands one edge after the request
      if (fetch_q) begin
        data_q <= mem_q[addr_q];
      end else if (wr_acc && hit(idx, `NVS_IDX_DATA)) begin
        data_q <= wbyte;
      end
      // full 8-bit address reaches all 256 cells
      if (wr_acc && hit(idx, `NVS_IDX_ADDR)) begin
        addr_q <= wbyte;
      end
      if (wr_acc && hit(idx, `NVS_IDX_INTCTL)) begin
        intctl_q <= wbyte;
      end
      if (wr_acc && hit(idx, `NVS_IDX_PIRQEN)) begin
        pirqen_q <= wbyte[`NVS_PIRQEN_DONE];
      end
      // completion sets the flag; the set beats a clear
      if (end_wr) begin
        done_q <= 1'b1;
      end else if (wr_acc && hit(idx, `NVS_IDX_PFLAGS)) begin
        done_q <= wbyte[`NVS_PFLAGS_DONE];
      end
    end
  end

  // ----------------------------------------------------------------
  // read path
  // ----------------------------------------------------------------
  // no protection gating on processor access
  reg [7:0] rd_byte;

  always @* begin
    rd_byte = 8'h00;
    case (idx)
      `NVS_IDX_INTCTL: begin
        rd_byte = intctl_q;
      end
      `NVS_IDX_PFLAGS: begin
        rd_byte = {done_q, 7'h00};
      end
      `NVS_IDX_PIRQEN: begin
        rd_byte = {pirqen_q, 7'h00};
      end
      `NVS_IDX_DATA: begin
        rd_byte = data_q;
      end
      `NVS_IDX_ADDR: begin
        rd_byte = addr_q;
      end
      `NVS_IDX_CTRL: begin
        rd_byte = {4'h0, abort_q, permit_q, go_q, fetch_q};
      end
      `NVS_IDX_UNLOCK: begin
        rd_byte = 8'h00;
      end
      default: begin
        rd_byte = 8'h00;
      end
    endcase
  end

  // captured in the wait cycle so it stands at the answering edge
  always @(posedge clk_sys or negedge rst_n_int) begin
    if (!rst_n_int) begin
      avs_readdata <= 32'h0000_0000;
    end else if (avs_read && !ack_q) begin
      avs_readdata <= {24'h00_0000, rd_byte};
    end
  end

endmodule // nvs_ctrl

`default_nettype wire

// File: test/nvs_ctrl_props.sv
// assertion checker for the nonvolatile store controller
`timescale 1ns/10ps
`default_nettype none
module nvs_ctrl_props #(
  parameter [31:0] POWERUP_TIMER_CYCLES = 32'd20,
  parameter [31:0] WRITE_CYCLES = 32'd10
) (
  // clock and reset
  input wire clk_sys,
  input wire rstn,
  // avalon-mm slave
  input wire [9:0] avs_address,
  input wire avs_read,
  input wire avs_write,
  input wire [31:0] avs_readdata,
  input wire avs_waitrequest
);
  // ----
  // bus properties
  // ----
  wire req = avs_read | avs_write;
  wire [7:0] idx = avs_address[9:2];
  wire rd_done = avs_read & ~avs_waitrequest;
  reg [31:0] up_q;
  // counts from power-on only, so brownout restarts are undercounted
  always @(posedge clk_sys or negedge rstn) begin
    if (!rstn)
      up_q <= 32'h0;
    else if (up_q < POWERUP_TIMER_CYCLES)
      up_q <= up_q + 32'h1;
  end
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rstn);
  a_wait_first: assert property ($rose(req) |-> avs_waitrequest)
    else $error("no wait state on new request");
  a_one_wait: assert property (req && avs_waitrequest |=> !avs_waitrequest)
    else $error("more than one wait state");
  a_idle_nowait: assert property (!req |-> !avs_waitrequest)
    else $error("wait without request");
  a_rdata_hold: assert property
    (!(avs_read && avs_waitrequest) |=> $stable(avs_readdata))
    else $error("read data changed outside a read");
  a_upper_zero: assert property (avs_readdata[31:8] == 24'h0)
    else $error("upper read lanes not zero");
  a_ctrl_upper: assert property (
    rd_done && idx == 8'h9c |-> avs_readdata[7:4] == 4'h0)
    else $error("control upper bits not zero");
  a_unlock_zero: assert property (
    rd_done && idx == 8'h9d |-> avs_readdata == 32'h0)
    else $error("unlock port read not zero");
  a_flag_bits: assert property (
    rd_done && (idx == 8'h0c || idx == 8'h8c) |-> avs_readdata[6:0] == 7'h0)
    else $error("foreign flag bits not zero");
  a_unmapped_zero: assert property (rd_done &&
    !(idx inside {8'h0b, 8'h0c, 8'h8c, 8'h9a, 8'h9b, 8'h9c, 8'h9d})
    |-> avs_readdata == 32'h0)
    else $error("unmapped read not zero");
  a_powerup_timer_block: assert property (
    rd_done && idx == 8'h9c && avs_readdata[1] |-> up_q >= POWERUP_TIMER_CYCLES)
    else $error("write started inside power-up time");
endmodule // nvs_ctrl_props
bind nvs_ctrl nvs_ctrl_props #(.POWERUP_TIMER_CYCLES(POWERUP_TIMER_CYCLES),
  .WRITE_CYCLES(WRITE_CYCLES)) u_props (.clk_sys(clk_sys), .rstn(rstn),
  .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
  .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest));
`default_nettype wire

// File: test/nvs_ctrl_tb.sv
// self-checking bench for the nonvolatile store controller
`timescale 1ns/10ps
`default_nettype none
`define CK(g, e) begin checks++; if ((g) !== (e)) begin miscompares++; \
  $display("[ERR] t=%0t got %h exp %h", $time, g, e); end end
module nvs_ctrl_tb;
  localparam [9:0] AFL = 10'h030;
  localparam [9:0] ADT = 10'h268;
  localparam [9:0] AAD = 10'h26c;
  localparam [9:0] ACT = 10'h270;
  localparam [9:0] AUL = 10'h274;
  reg clk_sys;
  reg rstn;
  reg ext_reset_n;
  reg watchdog_reset;
  reg brownout_detect;
  reg [9:0] avs_address;
  reg avs_read;
  reg avs_write;
  reg [3:0] avs_byteenable;
  reg [31:0] avs_writedata;
  wire [31:0] avs_readdata;
  wire avs_waitrequest;
  reg [25:0] rows [0:7];
  reg [31:0] q;
  integer miscompares;
  integer checks;
  integer i;
  integer j;
  // ----
  // device, clock, tasks
  // ----
  nvs_ctrl #(.POWERUP_TIMER_CYCLES(32'd60), .WRITE_CYCLES(32'd20)) DUT (
    .clk_sys(clk_sys), .rstn(rstn), .ext_reset_n(ext_reset_n),
    .watchdog_reset(watchdog_reset), .brownout_detect(brownout_detect),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_byteenable(avs_byteenable), .avs_writedata(avs_writedata),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest));
  initial begin
    clk_sys = 1'b0;
    forever #25 clk_sys = ~clk_sys;
  end
  task close_out;
    begin
      $display("checks %0d miscompares %0d", checks, miscompares);
      if (miscompares == 0 && checks > 0)
        $display("TB: PASS");
      else
        $display("TB: FAIL");
      $finish;
    end
  endtask
  // held until waitrequest is sampled low at a rising edge
  task bus(input rd, input [9:0] a, input [7:0] d);
    reg w;
    integer n;
    begin
      @(posedge clk_sys);
      avs_read <= rd;
      avs_write <= !rd;
      avs_address <= a;
      avs_writedata <= {24'h0, d};
      w = 1'b1;
      n = 0;
      while (w) begin
        @(posedge clk_sys);
        w = avs_waitrequest;
        // read data taken only at the answering edge
        if (!w)
          q = avs_readdata;
        n = n + 1;
        if (n > 20) begin
          miscompares++;
          close_out;
        end
      end
      avs_read <= 1'b0;
      avs_write <= 1'b0;
    end
  endtask
  task wr(input [9:0] a, input [7:0] d);
    bus(1'b0, a, d);
  endtask
  task chk(input [9:0] a, input [31:0] e);
    begin
      bus(1'b1, a, 8'h0);
      `CK(q, e)
    end
  endtask
  // gap adds one idle edge, breaking the exact spacing
  task seq(input [7:0] k1, input [7:0] k2, input gap);
    begin
      wr(AUL, k1);
      if (gap)
        @(posedge clk_sys);
      wr(AUL, k2);
      wr(ACT, 8'h06);
    end
  endtask
  task idle_wait;
    integer k;
    begin
      k = 0;
      q = 32'h2;
      while (q[1]) begin
        bus(1'b1, ACT, 8'h0);
        k = k + 1;
        if (k > 40) begin
          miscompares++;
          close_out;
        end
      end
    end
  endtask
  // ----
  // main sequence
  // ----
  initial begin
    rstn = 1'b0;
    ext_reset_n = 1'b1;
    watchdog_reset = 1'b0;
    brownout_detect = 1'b0;
    avs_address = 10'h0;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_byteenable = 4'hf;
    avs_writedata = 32'h0;
    miscompares = 0;
    checks = 0;
    rows[0] = {10'h02c, 8'ha5, 8'ha5};
    rows[1] = {AFL, 8'hff, 8'h80};
    rows[2] = {10'h230, 8'hff, 8'h80};
    rows[3] = {ADT, 8'h3c, 8'h3c};
    rows[4] = {AAD, 8'h10, 8'h10};
    rows[5] = {ACT, 8'hfc, 8'h0c};
    rows[6] = {AUL, 8'h55, 8'h00};
    rows[7] = {10'h3fc, 8'hff, 8'h00};
    repeat (10) @(posedge clk_sys);
    rstn <= 1'b1;
    repeat (3) @(posedge clk_sys);
    for (i = 0; i < 8; i++) chk(rows[i][25:16], 32'h0);
    for (i = 0; i < 8; i++) begin
      wr(rows[i][25:16], rows[i][15:8]);
      chk(rows[i][25:16], {24'h0, rows[i][7:0]});
    end
    wr(AFL, 8'h00);
    wr(10'h02c, 8'h00);
    wr(ADT, 8'hc3);
    wr(ACT, 8'h04);
    seq(8'h55, 8'haa, 1'b0);
    chk(ACT, 32'h06);
    wr(ACT, 8'h00);
    chk(ACT, 32'h02);
    idle_wait;
    chk(AFL, 32'h80);
    wr(AFL, 8'h00);
    wr(ADT, 8'h00);
    wr(ACT, 8'h01);
    chk(ADT, 32'hc3);
    chk(ACT, 32'h0);
    chk(ADT, 32'hc3);
    for (j = 0; j < 3; j++) begin
      wr(ACT, (j == 2) ? 8'h00 : 8'h04);
      seq((j == 1) ? 8'haa : 8'h55, (j == 1) ? 8'h55 : 8'haa, j == 0);
      chk(ACT, 32'h04);
    end
    chk(AFL, 32'h0);
    wr(ADT, 8'h3c);
    seq(8'h55, 8'haa, 1'b0);
    // fetch while programming sees the erased cell
    wr(ACT, 8'h05);
    chk(ADT, 32'hff);
    idle_wait;
    wr(ACT, 8'h01);
    chk(ADT, 32'h3c);
    avs_byteenable <= 4'h0;
    wr(ADT, 8'h99);
    avs_byteenable <= 4'hf;
    chk(ADT, 32'h3c);
    for (j = 0; j < 3; j++) begin
      wr(ACT, 8'h04);
      seq(8'h55, 8'haa, 1'b0);
      ext_reset_n <= (j != 0);
      watchdog_reset <= (j == 1);
      brownout_detect <= (j == 2);
      repeat (4) @(posedge clk_sys);
      ext_reset_n <= 1'b1;
      watchdog_reset <= 1'b0;
      brownout_detect <= 1'b0;
      repeat (4) @(posedge clk_sys);
      chk(ACT, 32'h08);
      chk(AAD, 32'h0);
    end
    wr(ACT, 8'h04);
    seq(8'h55, 8'haa, 1'b0);
    chk(ACT, 32'h04);
    close_out;
  end
endmodule // nvs_ctrl_tb
`default_nettype wire
